// ===== src/tone_gate_control.sv
// Purpose: decide when the internal tone or the external waveform drives the regulated output
// Assumes: control bits come from the host register logic on this clock
// Notes:   tone control input is a pin and is synchronised here
`timescale 1ns/1ps
`default_nettype none
module tone_gate_control
	import tone_gate_pkg::*;
(
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_n,
	input  wire tone_ctrl_t i_ctrl,
	input  wire logic       i_ctrl_wr,
	input  wire logic       i_tone_control_input,
	input  wire logic       i_supply_low_lockout,
	output var  logic       o_regulated_output_tone,
	output var  logic       o_tone_active,
	output var  tone_ctrl_t o_ctrl
);

	////////////////////////////////////////////////////////////////////////
	// Control bits, cleared and frozen while locked out

	tone_ctrl_t ctrl_ff;
	wire        lock = i_supply_low_lockout;

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n || lock)
			ctrl_ff <= '{CTRL_RST_VAL, CTRL_RST_VAL};
		else if (i_ctrl_wr)
			ctrl_ff <= i_ctrl;
	end

	assign o_ctrl = ctrl_ff;

	////////////////////////////////////////////////////////////////////////
	// Pin synchroniser: stage 1 only feeds stage 2

	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic pin_ff;

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			s1_ff  <= 1'b0;
			s2_ff  <= 1'b0;
			s3_ff  <= 1'b0;
			pin_ff <= 1'b0;
		end
		else
		begin
			s1_ff  <= i_tone_control_input;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			pin_ff <= (s2_ff == s3_ff) ? s2_ff : pin_ff;
		end
	end

	logic pin_d_ff;
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			pin_d_ff <= 1'b0;
		else
			pin_d_ff <= pin_ff;
	end

	wire pin_edge = pin_ff ^ pin_d_ff;
	wire ext_sel  = ctrl_ff.ext_mode & ctrl_ff.tone_en;
	wire env_sel  = ~ctrl_ff.ext_mode & ctrl_ff.tone_en;
	wire enabled  = ctrl_ff.tone_en & ~lock;

	////////////////////////////////////////////////////////////////////////
	// Gate state machine
	// External mode: any edge is activity; silence for the stop time ends it.
	// Envelope mode: level high is activity; low for the stop time ends it.

	gate_state_t      state_ff;
	gate_state_t      nxt_state;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;

	wire idle_act = ext_sel ? pin_edge : pin_ff;
	wire [CNT_W-1:0] start_lim = ext_sel ? CNT_W'(EXT_START_CYC)
	                                     : CNT_W'(ENV_START_CYC);
	wire [CNT_W-1:0] stop_lim  = ext_sel ? CNT_W'(EXT_STOP_CYC)
	                                     : CNT_W'(ENV_STOP_CYC);
	wire quiet = ext_sel ? ~pin_edge : ~pin_ff;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		case (state_ff)
			ST_IDLE:
			begin
				nxt_cnt = '0;
				if (idle_act)
					nxt_state = ST_START;
			end
			ST_START:
			begin
				nxt_cnt = cnt_ff + CNT_W'(1);
				if (cnt_ff >= start_lim - CNT_W'(1))
				begin
					nxt_state = ST_ON;
					nxt_cnt   = '0;
				end
			end
			ST_ON:
			begin
				nxt_cnt = quiet ? cnt_ff + CNT_W'(1) : '0;
				if (quiet && cnt_ff >= stop_lim - CNT_W'(1))
				begin
					nxt_state = ST_IDLE;
					nxt_cnt   = '0;
				end
			end
			default:
			begin
				nxt_state = ST_IDLE;
				nxt_cnt   = '0;
			end
		endcase
		if (!enabled)
		begin
			nxt_state = ST_IDLE;
			nxt_cnt   = '0;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			state_ff <= ST_IDLE;
			cnt_ff   <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
		end
	end

	wire gate_on = (state_ff == ST_ON) & enabled;

	////////////////////////////////////////////////////////////////////////
	// Tone source. In external mode the waveform sets frequency and duty;
	// the analog shaping after this pin sets rise, fall and amplitude.

	logic osc_tone;

	tone_osc u_osc (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_run      (gate_on & env_sel),
		.o_tone     (osc_tone)
	);

	logic out_ff;
	// Continuous tone is envelope mode with the pin held high
	wire nxt_out = gate_on & (ext_sel ? pin_ff : osc_tone);

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			out_ff <= 1'b0;
		else
			out_ff <= nxt_out;
	end

	logic act_ff;
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			act_ff <= 1'b0;
		else
			act_ff <= gate_on;
	end

	assign o_regulated_output_tone = out_ff;
	assign o_tone_active           = act_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks

	no_tone_off_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		!ctrl_ff.tone_en |=> !o_tone_active)
		else $error("tone active with enable clear");

	lock_quiet_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		lock |=> (!o_regulated_output_tone && ctrl_ff == '0))
		else $error("activity during lockout");

	lock_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		lock && i_ctrl_wr |=> !ctrl_ff.tone_en)
		else $error("control written during lockout");

	ext_start_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		state_ff == ST_START && ext_sel && enabled |=>
		(state_ff == ST_ON) ==
		($past(cnt_ff) >= CNT_W'(EXT_START_CYC - 1)))
		else $error("external start at wrong time");

	ext_follow_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		gate_on && ext_sel |=> o_regulated_output_tone == $past(pin_ff))
		else $error("output not following waveform");

	env_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		env_sel && !gate_on |=> !o_regulated_output_tone)
		else $error("tone outside envelope");

	stop_cnt_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		state_ff == ST_ON && !quiet |=> cnt_ff == '0 || state_ff != ST_ON)
		else $error("stop timer not restarted by activity");

	env_stop_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$fell(gate_on) && env_sel |-> $past(cnt_ff) >= CNT_W'(ENV_STOP_CYC - 1)
		|| !enabled)
		else $error("envelope stop too early");

endmodule
`default_nettype wire

// ===== src/tone_gate_pkg.sv
// Purpose: constants and types shared by the tone gate control block
// Assumes: 100 MHz core clock
// Notes:   timing figures are kept in ns and converted to cycles here
package tone_gate_pkg;

	localparam int CLK_PERIOD_NS     = 10;
	localparam int EXT_START_NS      = 1000;
	localparam int EXT_STOP_NS       = 60000;
	localparam int ENV_START_NS      = 6000;
	localparam int ENV_STOP_MIN_NS   = 15000;
	localparam int ENV_STOP_MAX_NS   = 60000;
	localparam int TONE_HALF_NS      = 22727;

	localparam int EXT_START_CYC = EXT_START_NS / CLK_PERIOD_NS;
	localparam int EXT_STOP_CYC  = EXT_STOP_NS / CLK_PERIOD_NS;
	localparam int ENV_START_CYC = ENV_START_NS / CLK_PERIOD_NS;
	// Envelope stop picked inside the window, midway
	localparam int ENV_STOP_CYC  =
		(ENV_STOP_MIN_NS + ENV_STOP_MAX_NS) / (2 * CLK_PERIOD_NS);
	// Half period of 22 kHz, rounded down
	localparam int TONE_HALF_CYC = TONE_HALF_NS / CLK_PERIOD_NS;

	localparam int CNT_W = 16;

	localparam logic       CTRL_RST_VAL = 1'b0;
	localparam logic [1:0] SYNC_RST_VAL = 2'h0;

	typedef struct packed {
		logic ext_mode;
		logic tone_en;
	} tone_ctrl_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_START,
		ST_ON,
		ST_STOP
	} gate_state_t;

endpackage

// ===== src/tone_osc.sv
// Purpose: internal 22 kHz square tone generator
// Assumes: enabled only by the gate controller
// Notes:   phase restarts low whenever disabled
`timescale 1ns/1ps
`default_nettype none
module tone_osc
	import tone_gate_pkg::*;
(
	input  wire logic i_core_clk,
	input  wire logic i_rst_n,
	input  wire logic i_run,
	output var  logic o_tone
);

	logic [CNT_W-1:0] cnt_ff;
	logic             tone_ff;
	wire              wrap = (cnt_ff == CNT_W'(TONE_HALF_CYC - 1));

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n || !i_run)
		begin
			cnt_ff  <= '0;
			tone_ff <= 1'b0;
		end
		else
		begin
			cnt_ff  <= wrap ? '0 : cnt_ff + CNT_W'(1);
			tone_ff <= wrap ? ~tone_ff : tone_ff;
		end
	end

	assign o_tone = tone_ff;

endmodule
`default_nettype wire

// ===== verification/tb_tone_gate_control.sv
// Purpose: self-checking bench for the tone gate control
// Assumes: design timing figures fixed at 100 MHz
// Notes:   expected results are queued and checked by a monitor
`timescale 1ns/1ps
`default_nettype none
module tb_tone_gate_control;
	import tone_gate_pkg::*;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [1:0] ctrl = 2'h0;
	logic       wr = 1'b0;
	logic       lock = 1'b0;
	logic [1:0] mode = 2'h0;
	logic       pin;
	logic       tone;
	logic       act;
	tone_ctrl_t octrl;
	logic [4:0] q[$];
	event       smp;
	int         error_cnt = 0;
	int         checked = 0;
	// Half period of a 22 kHz tone in 10 ns clocks
	localparam int TONE_HALF = 2272;
	always #5 clk = ~clk;
	tone_host_model host (.i_core_clk(clk), .i_mode(mode), .o_pin(pin));
	tone_gate_control uut (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_ctrl(tone_ctrl_t'(ctrl)),
		.i_ctrl_wr(wr), .i_tone_control_input(pin),
		.i_supply_low_lockout(lock), .o_regulated_output_tone(tone),
		.o_tone_active(act), .o_ctrl(octrl));
	task automatic check(input logic [4:0] seen, input logic [4:0] exp);
		checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Tone bit only compared when its phase is known
	task automatic note(input logic [1:0] c, input logic a,
			input logic t, input logic care);
		q.push_back({care, c, a, t});
		->smp;
	endtask
	task automatic write(input logic [1:0] c);
		ctrl = c;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
		tick(1);
	endtask
	always @(smp)
	begin
		logic [4:0] e;
		e = q.pop_front();
		check({e[4], octrl, act, e[4] & tone}, {e[4], e[3:0] & {3'h7, e[4]}});
	end
	task automatic complete_run;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		#400_000;
		error_cnt++;
		complete_run();
	end
	initial
	begin
		logic [1:0] r;
		void'($urandom(87));
		tick(2);
		rst_n = 1'b1;
		note(2'h0, 1'b0, 1'b0, 1'b1);
		repeat (4)
		begin
			r = 2'($urandom);
			write(r);
			note(r, 1'b0, 1'b0, 1'b1);
		end
		// Bits are set before the waveform starts
		write(2'h3);
		mode = 2'h2;
		tick(60);
		note(2'h3, 1'b0, 1'b0, 1'b1);
		tick(100);
		note(2'h3, 1'b1, 1'b1, 1'b1);
		repeat (3)
		begin
			@(pin);
			tick(20);
			note(2'h3, 1'b1, pin, 1'b1);
		end
		mode = 2'h0;
		tick(5000);
		note(2'h3, 1'b1, 1'b0, 1'b0);
		tick(1200);
		note(2'h3, 1'b0, 1'b0, 1'b1);
		write(2'h1);
		mode = 2'h1;
		tick(400);
		note(2'h1, 1'b0, 1'b0, 1'b1);
		tick(400);
		note(2'h1, 1'b1, 1'b0, 1'b0);
		@(posedge tone);
		tick(TONE_HALF - 10);
		note(2'h1, 1'b1, 1'b1, 1'b1);
		tick(20);
		note(2'h1, 1'b1, 1'b0, 1'b1);
		mode = 2'h0;
		tick(1400);
		note(2'h1, 1'b1, 1'b0, 1'b0);
		tick(4800);
		note(2'h1, 1'b0, 1'b0, 1'b1);
		write(2'h2);
		mode = 2'h2;
		tick(1000);
		note(2'h2, 1'b0, 1'b0, 1'b1);
		write(2'h1);
		mode = 2'h1;
		tick(1000);
		note(2'h1, 1'b1, 1'b0, 1'b0);
		lock = 1'b1;
		tick(2);
		note(2'h0, 1'b0, 1'b0, 1'b1);
		r = 2'($urandom);
		write(r | 2'h1);
		tick(1);
		note(2'h0, 1'b0, 1'b0, 1'b1);
		lock = 1'b0;
		tick(1000);
		note(2'h0, 1'b0, 1'b0, 1'b1);
		tick(2);
		complete_run();
	end
endmodule
`default_nettype wire

// ===== verification/tone_host_model.sv
// Purpose: host side driving the tone control pin
// Assumes: mode 0 holds low, 1 holds high, 2 sends a 22 kHz square
// Notes:   square restarts with a toggle of the pin on entry to mode 2, a rising edge when entered from mode 0
`timescale 1ns/1ps
`default_nettype none
module tone_host_model
	import tone_gate_pkg::*;
(
	input  wire logic       i_core_clk,
	input  wire logic [1:0] i_mode,
	output var  logic       o_pin
);
	localparam int HALF_CYC = 2272;
	int cnt = 0;
	initial o_pin = 1'b0;
	always @(posedge i_core_clk)
	begin
		cnt <= (i_mode == 2'h2 && cnt < HALF_CYC - 1) ? cnt + 1 : 0;
		if (i_mode == 2'h1)
			o_pin <= 1'b1;
		else if (i_mode == 2'h0)
			o_pin <= 1'b0;
		else if (cnt == 0)
			o_pin <= ~o_pin;
	end
endmodule
`default_nettype wire
